/* File: phy_mgmt_mode_control.sv */
/*
  PHY management serial slave with mode control: MDC/MDIO frame
  decoder, 16-bit register file, interrupt, crossover, repeater and
  loopback steering, plus an AXI4-Lite status window.
  Assumes MDC, MDIO, strap, pair sense and event inputs are asynchronous and
  are synchronised here; the bench resolves the MDIO wire.
*/
// Notes on behaviour
// - Frame: 32 ones, start 01, opcode, PHY addr, reg addr, TA, 16 data.
// - Read TA: host releases, device drives zero; write TA is 1 then 0.
// - Device answers only address 0h or 3h chosen by strap.
// - Address 0h is broadcast after power-up; writes and reads accepted.
// - Register 16h bit 9 set makes 0h an ordinary unique address.
// - All registers 16 bits; 0-8 standard, higher ones vendor.
// - Register 1Bh bits 15:8 enable conditions onto the interrupt pin.
// - Register 1Bh bits 7:0 latch conditions, cleared by reading it.
// - Register 1Fh bit 9 sets interrupt polarity; default active low.
// - Auto crossover on after reset; sense pairs; bit 13 disables it.
// - With auto crossover off, 1Fh bit 14 forces MDI or MDI-X.
// - MDI transmits on pair one, receives pair two; MDI-X swaps.
// - 16h bits 6 and 1 enable back-to-back relay of receive stream.
// - Register 0h bit 14 local loopback; bits 13, 12, 8 set mode.
// - Local loopback returns MAC frames to MAC and still sends to line.
// - Register 1Fh bit 3 disables line transmitter; clear re-enables.
// - Remote loopback returns line frames; only 100 Mbps full duplex.
// - Interrupt pin signals register status change without polling.
// - Register 1Fh bit 2 enables remote loopback.
// - With autoneg off, 0h bit 13 sets speed and bit 8 duplex.
`timescale 1ns/1ps
module phy_mgmt_mode_control
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   mdc,
  input  wire logic                   mdio_i,
  output logic                        mdio_o,
  output logic                        mdio_oe_n,
  input  wire logic [1:0]             phy_address_strap,
  output logic                        interrupt_pin,
  input  wire logic [7:0]             int_events,
  input  wire logic                   pair1_sense,
  input  wire logic                   pair2_sense,
  output logic                        mdix_active,
  input  wire phy_mgmt_pkg::rmii_t    mac_tx,
  output phy_mgmt_pkg::rmii_t         mac_rx,
  input  wire phy_mgmt_pkg::rmii_t    line_rx,
  output phy_mgmt_pkg::rmii_t         line_tx,
  output phy_mgmt_pkg::rmii_t         peer_tx,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  phy_mgmt_pkg::blk_state_t s;
  phy_mgmt_pkg::blk_state_t next_s;

  // Two-stage synchronisers for MDC, MDIO, strap, pair sense and event pins
  logic [1:0] mdc_sync;
  logic [1:0] mdio_sync;
  logic [3:0] strap_sync;
  logic [1:0] p1_sync;
  logic [1:0] p2_sync;
  logic [15:0] ev_sync;
  logic       mdc_last;
  logic       mdc_rise;
  logic       mdc_fall;

  always_ff @(posedge aclk)
  begin
    mdc_sync   <= {mdc_sync[0], mdc};
    mdio_sync  <= {mdio_sync[0], mdio_i};
    strap_sync <= {strap_sync[1:0], phy_address_strap};
    p1_sync    <= {p1_sync[0], pair1_sense};
    p2_sync    <= {p2_sync[0], pair2_sense};
    ev_sync    <= {ev_sync[7:0], int_events};
    mdc_last   <= mdc_sync[1];
  end

  // Edge detection works on the second stage only
  assign mdc_rise = mdc_sync[1] & ~mdc_last;
  assign mdc_fall = ~mdc_sync[1] & mdc_last;

  // Register read mux used by the frame engine at TA
  function automatic logic [15:0] reg_read
  (
    input phy_mgmt_pkg::blk_state_t st,
    input logic [4:0]               idx
  );
    logic [15:0] v;
    v = 16'h0000;
    unique case (idx)
      phy_mgmt_pkg::REG_BASIC_CTRL: v = st.basic_ctrl;
      phy_mgmt_pkg::REG_OPER_MODE:  v = st.oper_mode;
      phy_mgmt_pkg::REG_INT_CTRL:   v = st.int_ctrl;
      phy_mgmt_pkg::REG_PHY_CTRL2:  v = st.phy_ctrl2;
      default:                      v = 16'h0000;
    endcase
    return v;
  endfunction : reg_read

  logic       bit_in;
  logic [4:0] f_phy;
  logic [4:0] f_reg;
  logic       addr_hit;
  logic       int_clr;
  logic       remote_ok;
  logic       b2b;
  logic [7:0] int_set;

  always_comb
  begin
    next_s   = s;
    bit_in   = mdio_sync[1];
    f_phy    = s.hdr[9:5];
    f_reg    = s.hdr[4:0];
    // Unique 0h or 3h by strap, plus broadcast 0h until disabled
    addr_hit = (f_phy == (s.strap != 2'b00 ? phy_mgmt_pkg::ADDR_ALT
                          : phy_mgmt_pkg::ADDR_BCAST)) ||
               (f_phy == phy_mgmt_pkg::ADDR_BCAST &&
                !s.oper_mode[phy_mgmt_pkg::OM_NO_BCAST]);
    int_clr  = 1'b0;
    int_set  = ev_sync[15:8];

    // Strap caught once after reset release
    if (!s.strap_done)
    begin
      next_s.strap      = strap_sync[3:2];
      next_s.strap_done = 1'b1;
    end

    // Frame engine, bits sampled on rising MDC, MSB first
    if (mdc_rise)
    begin
      unique case (s.st)
        phy_mgmt_pkg::M_IDLE,
        phy_mgmt_pkg::M_PRE:
        begin
          if (bit_in)
          begin
            if (s.cnt != phy_mgmt_pkg::PREAMBLE_LEN)
              next_s.cnt = s.cnt + 6'd1;
            next_s.st = phy_mgmt_pkg::M_PRE;
          end
          else if (s.cnt == phy_mgmt_pkg::PREAMBLE_LEN)
          begin
            next_s.st  = phy_mgmt_pkg::M_HDR;
            next_s.hdr = 14'h0000;
            next_s.cnt = 6'd0;
          end
          else
          begin
            next_s.cnt = 6'd0;
            next_s.st  = phy_mgmt_pkg::M_IDLE;
          end
        end
        phy_mgmt_pkg::M_HDR:
        begin
          // Start second bit, opcode, addresses
          next_s.hdr = {s.hdr[12:0], bit_in};
          next_s.cnt = s.cnt + 6'd1;
          if (s.cnt == phy_mgmt_pkg::HDR_BITS - 6'd2)
          begin
            next_s.st = phy_mgmt_pkg::M_TA;
            next_s.cnt = 6'd0;
          end
        end
        phy_mgmt_pkg::M_TA:
        begin
          next_s.cnt = s.cnt + 6'd1;
          if (s.cnt == 6'd0)
          begin
            // Header now complete: start=1, opcode, addresses
            next_s.rd   = s.hdr[11:10] == phy_mgmt_pkg::OP_READ;
            next_s.mine = addr_hit && s.hdr[12] &&
                          (s.hdr[11:10] == phy_mgmt_pkg::OP_READ ||
                           s.hdr[11:10] == phy_mgmt_pkg::OP_WRITE);
            next_s.sh   = reg_read(s, f_reg);
          end
          else
          begin
            next_s.st  = phy_mgmt_pkg::M_DATA;
            next_s.cnt = 6'd0;
            if (s.rd && s.mine)
            begin
              // Reading the interrupt register clears its status bits
              if (f_reg == phy_mgmt_pkg::REG_INT_CTRL)
                int_clr = 1'b1;
            end
          end
        end
        phy_mgmt_pkg::M_DATA:
        begin
          next_s.cnt = s.cnt + 6'd1;
          if (!s.rd)
            next_s.sh = {s.sh[14:0], bit_in};
          if (s.cnt == phy_mgmt_pkg::DATA_BITS - 6'd1)
          begin
            next_s.st  = phy_mgmt_pkg::M_IDLE;
            next_s.cnt = 6'd0;
            if (!s.rd && s.mine)
            begin
              // Write completes on the last data bit
              unique case (f_reg)
                phy_mgmt_pkg::REG_BASIC_CTRL:
                  next_s.basic_ctrl = {s.sh[14:0], bit_in};
                phy_mgmt_pkg::REG_OPER_MODE:
                  next_s.oper_mode = {s.sh[14:0], bit_in};
                phy_mgmt_pkg::REG_INT_CTRL:
                  next_s.int_ctrl[15:8] = s.sh[14:7];
                phy_mgmt_pkg::REG_PHY_CTRL2:
                  next_s.phy_ctrl2 = {s.sh[14:0], bit_in};
                default:
                  next_s.int_ctrl[15:8] = s.int_ctrl[15:8];
              endcase
            end
          end
        end
      endcase
    end

    // Device drives MDIO after falling MDC: zero in TA, then data
    if (mdc_fall)
    begin
      if (s.st == phy_mgmt_pkg::M_TA && s.cnt == 6'd1 && s.rd && s.mine)
      begin
        next_s.mdio_oe_n = 1'b0;
        next_s.mdio_o    = 1'b0;
      end
      else if (s.st == phy_mgmt_pkg::M_DATA && s.rd && s.mine)
      begin
        next_s.mdio_oe_n = 1'b0;
        next_s.mdio_o    = s.sh[15];
        next_s.sh        = {s.sh[14:0], 1'b0};
      end
      else
      begin
        next_s.mdio_oe_n = 1'b1;
        next_s.mdio_o    = 1'b0;
      end
    end

    // Status latch: an event in the clearing cycle survives
    next_s.int_ctrl[7:0] = (int_clr ? 8'h00 : s.int_ctrl[7:0]) |
                           int_set;
    next_s.irq = |(s.int_ctrl[15:8] & s.int_ctrl[7:0]);

    // Crossover: auto follows sensed pair, else forced by bit 14
    if (s.phy_ctrl2[phy_mgmt_pkg::PC_AUTOX_DIS])
      next_s.mdix = s.phy_ctrl2[phy_mgmt_pkg::PC_MDIX_SEL];
    else if (p1_sync[1] != p2_sync[1])
      next_s.mdix = p1_sync[1];

    // Remote loopback only at 100 Mbps full duplex
    remote_ok = s.phy_ctrl2[phy_mgmt_pkg::PC_REM_LOOP] &&
                s.basic_ctrl[phy_mgmt_pkg::BC_SPEED] &&
                s.basic_ctrl[phy_mgmt_pkg::BC_DUPLEX];
    b2b = s.oper_mode[phy_mgmt_pkg::OM_B2B_HI] &&
          s.oper_mode[phy_mgmt_pkg::OM_B2B_LO];

    // Data steering; line side is post-crossover pair one
    next_s.mac_rx = s.basic_ctrl[phy_mgmt_pkg::BC_LOOPBACK] ?
                    mac_tx : line_rx;
    if (s.phy_ctrl2[phy_mgmt_pkg::PC_TX_DIS])
      next_s.line_tx = '0;
    else if (remote_ok)
      next_s.line_tx = line_rx;
    else
      next_s.line_tx = mac_tx;
    next_s.peer_tx = b2b ? line_rx : '0;

    // AXI4-Lite: write address and data in either order
    next_s.awready = s_axi_awvalid && !s.awready && !s.awtaken && !s.bvalid;
    next_s.wready  = s_axi_wvalid && !s.wready && !s.wtaken && !s.bvalid;
    next_s.awtaken = s.awtaken || (s.awready && s_axi_awvalid);
    next_s.wtaken  = s.wtaken || (s.wready && s_axi_wvalid);
    if (s.awtaken && s.wtaken && !s.bvalid)
    begin
      next_s.bvalid  = 1'b1;
      next_s.bresp   = phy_mgmt_pkg::RESP_SLVERR;           // Read-only map
      next_s.awtaken = 1'b0;
      next_s.wtaken  = 1'b0;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    next_s.arready = s_axi_arvalid && !s.rvalid && !s.arready;
    if (s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = phy_mgmt_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        phy_mgmt_pkg::AXI_STATUS:
          next_s.rdata = {16'h0000, s.strap, 10'h000, s.mdix,
                          s.irq, 1'b0, remote_ok};
        phy_mgmt_pkg::AXI_EVENTS:
          next_s.rdata = {16'h0000, s.int_ctrl};
        default:
        begin
          next_s.rdata = 32'h00000000;
          next_s.rresp = phy_mgmt_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
  end

  // Single state register with synchronous reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s            <= '0;
      s.st         <= phy_mgmt_pkg::M_IDLE;
      s.basic_ctrl <= phy_mgmt_pkg::BASIC_CTRL_RST;
      s.oper_mode  <= phy_mgmt_pkg::OPER_MODE_RST;
      s.phy_ctrl2  <= phy_mgmt_pkg::PHY_CTRL2_RST;
      s.int_ctrl   <= phy_mgmt_pkg::INT_CTRL_RST;
      s.mdio_oe_n  <= 1'b1;
    end
    else
      s <= next_s;
  end

  // Outputs straight from flip-flops; polarity bit applied in a flop
  logic int_out;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      int_out <= 1'b1;
    else
      int_out <= s.phy_ctrl2[phy_mgmt_pkg::PC_INT_POL] ?
                 s.irq : ~s.irq;
  end

  assign interrupt_pin = int_out;
  assign mdio_o        = s.mdio_o;
  assign mdio_oe_n     = s.mdio_oe_n;
  assign mdix_active   = s.mdix;
  assign mac_rx        = s.mac_rx;
  assign line_tx       = s.line_tx;
  assign peer_tx       = s.peer_tx;
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // Assertions
  int_polarity_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 $past(s.phy_ctrl2[9]) == 1'b0 |-> interrupt_pin == ~$past(s.irq))
    else $error("interrupt polarity wrong");
  irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.int_ctrl[15:8] & s.int_ctrl[7:0]) == 8'h00 |=> !s.irq)
    else $error("interrupt without enabled cause");
  status_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    int_clr && int_set == 8'h00 |=> s.int_ctrl[7:0] == 8'h00)
    else $error("status not cleared by read");
  set_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
    int_set != 8'h00 |=> (s.int_ctrl[7:0] & $past(int_set)) == $past(int_set))
    else $error("event lost");
  tx_disable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s.phy_ctrl2[3] |=> line_tx == '0)
    else $error("transmitter not disabled");
  local_loop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s.basic_ctrl[14] |=> mac_rx == $past(mac_tx))
    else $error("local loopback path wrong");
  b2b_relay_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(s.oper_mode[6] && s.oper_mode[1]) |=> peer_tx == '0)
    else $error("relay active while off");
  forced_mdix_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s.phy_ctrl2[13] |=> s.mdix == $past(s.phy_ctrl2[14]))
    else $error("forced crossover ignored");
  drive_ta_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !s.mine |=> mdio_oe_n || $past(!mdio_oe_n))
    else $error("drive for foreign frame");

endmodule : phy_mgmt_mode_control

/* File: phy_mgmt_pkg.sv */
/*
  Package for the PHY management and mode control block: register
  indices, field positions, reset values and carrier structs.
  Assumes a single 10 MHz system clock and an AXI4-Lite master.
*/
package phy_mgmt_pkg;

  // Management register indices (16-bit registers)
  localparam logic [4:0] REG_BASIC_CTRL = 5'h00;
  localparam logic [4:0] REG_OPER_MODE  = 5'h16;
  localparam logic [4:0] REG_INT_CTRL   = 5'h1B;
  localparam logic [4:0] REG_PHY_CTRL2  = 5'h1F;

  // Field positions
  localparam int BC_LOOPBACK   = 14;
  localparam int BC_SPEED      = 13;
  localparam int BC_AN_EN      = 12;
  localparam int BC_DUPLEX     = 8;
  localparam int OM_B2B_HI     = 6;
  localparam int OM_B2B_LO     = 1;
  localparam int OM_NO_BCAST   = 9;
  localparam int PC_MDIX_SEL   = 14;
  localparam int PC_AUTOX_DIS  = 13;
  localparam int PC_INT_POL    = 9;
  localparam int PC_CLK50_SEL  = 7;
  localparam int PC_TX_DIS     = 3;
  localparam int PC_REM_LOOP   = 2;

  // Reset values: autoneg on, 100M, full duplex; crossover auto
  localparam logic [15:0] BASIC_CTRL_RST = 16'h3100;
  localparam logic [15:0] OPER_MODE_RST  = 16'h0000;
  localparam logic [15:0] PHY_CTRL2_RST  = 16'h0000;
  localparam logic [15:0] INT_CTRL_RST   = 16'h0000;

  // Frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'd32;
  localparam logic [1:0] OP_READ      = 2'b10;
  localparam logic [1:0] OP_WRITE     = 2'b01;
  localparam logic [4:0] ADDR_BCAST   = 5'h00;
  localparam logic [4:0] ADDR_ALT     = 5'h03;
  localparam logic [5:0] HDR_BITS     = 6'd14;
  localparam logic [5:0] DATA_BITS    = 6'd16;

  // AXI4-Lite map of block-local registers
  localparam logic [7:0] AXI_STATUS   = 8'h00;
  localparam logic [7:0] AXI_EVENTS   = 8'h04;
  localparam logic [1:0] RESP_OKAY    = 2'b00;
  localparam logic [1:0] RESP_SLVERR  = 2'b10;

  // Timing of the management link
  localparam int MDC_PERIOD_NS  = 800;
  localparam int CLK_PERIOD_NS  = 100;

  typedef enum {
    M_IDLE, M_PRE, M_HDR, M_TA, M_DATA
  } mgmt_state_t;

  // RMII dibit stream
  typedef struct packed {
    logic       en;
    logic [1:0] d;
  } rmii_t;

  typedef struct packed {
    mgmt_state_t  st;
    logic [5:0]   cnt;
    logic [13:0]  hdr;
    logic [15:0]  sh;
    logic         rd;
    logic         mine;
    logic [15:0]  basic_ctrl;
    logic [15:0]  oper_mode;
    logic [15:0]  phy_ctrl2;
    logic [15:0]  int_ctrl;
    logic [1:0]   strap;
    logic         strap_done;
    logic         mdio_o;
    logic         mdio_oe_n;
    logic         irq;
    logic         mdix;
    rmii_t        mac_rx;
    rmii_t        line_tx;
    rmii_t        peer_tx;
    logic         awtaken;
    logic         wtaken;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic         arready;
    logic         awready;
    logic         wready;
  } blk_state_t;

endpackage : phy_mgmt_pkg

/* File: mdio_host_model.sv */
/*
  MDIO controller model: makes MDC (800 ns, still between frames)
  and sends clause 22 frames. Assumes the bench resolves the wire
  with a pull-up and runs aclk at 100 ns.
*/
`timescale 1ns/1ps
module mdio_host_model
(
  input  wire logic aclk,
  input  wire logic mdio_wire,
  output logic      mdc,
  output logic      h_d,
  output logic      h_en
);
  // Idle: clock low, line released
  initial
  begin
    mdc = 1'b0;
    h_d = 1'b1;
    h_en = 1'b0;
  end

  // One MDC period; sample late in the high phase, since the device
  // only moves the wire a few clocks after the falling edge
  task automatic bit_cyc(input logic en, b, output logic s);
    @(posedge aclk);
    mdc <= 1'b0;
    h_en <= en;
    h_d <= b;
    repeat (4) @(posedge aclk);
    mdc <= 1'b1;
    repeat (3) @(posedge aclk);
    #1 s = mdio_wire;
  endtask : bit_cyc

  // Whole frame, MSB first; on a read the line is released from TA
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, ra,
                       input logic [15:0] wd, output logic [15:0] rd,
                       output logic ta);
    logic        s;
    logic [13:0] h;
    logic        wr;
    h = {2'b01, op, pa, ra};
    wr = (op == phy_mgmt_pkg::OP_WRITE);
    repeat (32) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, h[i], s);
    bit_cyc(wr, 1'b1, s);
    bit_cyc(wr, 1'b0, ta);
    for (int i = 15; i >= 0; i--) bit_cyc(wr, wd[i], rd[i]);
    bit_cyc(1'b0, 1'b1, s);
    @(posedge aclk);
    mdc <= 1'b0;
  endtask : frame
endmodule : mdio_host_model

/* File: tb_top.sv */
/*
  Self-checking bench for the PHY management block: MDIO frames via
  the host model, AXI4-Lite status reads, events and streams.
  Assumes a pull-up on MDIO and a strap of 11 (address 3h).
*/
`timescale 1ns/1ps
module tb_top;
  logic aclk, aresetn, mdc, mdio_i, mdio_o, mdio_oe_n, h_d, h_en;
  logic [1:0] phy_address_strap, s_axi_bresp, s_axi_rresp;
  logic [7:0] int_events, s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic interrupt_pin, pair1_sense, pair2_sense, mdix_active;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  phy_mgmt_pkg::rmii_t mac_tx, mac_rx, line_rx, line_tx, peer_tx;
  integer seed;
  int mismatches, samples_checked;

  // Wire level: device, else host, else the pull-up
  assign mdio_i = !mdio_oe_n ? mdio_o : (h_en ? h_d : 1'b1);

  phy_mgmt_mode_control uut (.*);
  mdio_host_model host (.aclk(aclk), .mdio_wire(mdio_i), .mdc(mdc),
                        .h_d(h_d), .h_en(h_en));

  // 10 MHz system clock
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic wrap_up;
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // AXI read: request held until arready, rready until rvalid
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // AXI write: address and data offered together, each dropped alone
  task automatic axi_wr(input logic [7:0] a, output logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= 32'($random(seed));
    while (!(aw && w))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1;
      if (s_axi_wready === 1'b1) w = 1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // A silent device leaves the pull-up: all ones and TA high
  task automatic rdreg(input logic [4:0] pa, ra, input logic [15:0] e);
    logic [15:0] g;
    logic        t;
    host.frame(phy_mgmt_pkg::OP_READ, pa, ra, 16'h0000, g, t);
    chk(g, e);
    chk(t, e === 16'hFFFF);
  endtask : rdreg

  task automatic wrreg(input logic [4:0] pa, ra, input logic [15:0] v);
    logic [15:0] g;
    logic        t;
    host.frame(phy_mgmt_pkg::OP_WRITE, pa, ra, v, g, t);
  endtask : wrreg

  // Events held two clocks so the synchroniser cannot miss them
  task automatic pulse(input logic [7:0] ev);
    @(posedge aclk);
    int_events <= ev;
    repeat (2) @(posedge aclk);
    int_events <= 8'h00;
    repeat (6) @(posedge aclk);
  endtask : pulse

  // Random dibits in; outputs checked one clock later
  task automatic stream(input int m);
    phy_mgmt_pkg::rmii_t pm, pl, v;
    for (int i = 0; i < 24; i++)
    begin
      @(posedge aclk);
      pm = mac_tx;
      pl = line_rx;
      v = 3'($random(seed));
      mac_tx <= v.en ? v : 3'h0;
      v = 3'($random(seed));
      line_rx <= v.en ? v : 3'h0;
      #1;
      if (m == 0) chk(mac_rx, pm);
      if (m == 0) chk(line_tx, pm);
      if (m == 1) chk(line_tx.en, 1'b0);
      if (m == 2) chk(line_tx, pl);
      if (m == 3) chk(peer_tx, pl);
    end
  endtask : stream

  // Hang guard, well beyond about 10000 clocks of tests
  initial
  begin
    #4000000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  en;
    seed = 72571;
    aresetn = 1'b0;
    phy_address_strap = 2'b11;
    {int_events, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, pair1_sense, pair2_sense} = '0;
    {mac_tx, line_rx, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(8'h08, d, r);
    chk(d, 32'h00000000);
    chk(r, phy_mgmt_pkg::RESP_SLVERR);
    axi_wr(8'h00, r);
    chk(r, phy_mgmt_pkg::RESP_SLVERR);
    axi_rd(8'h00, d, r);
    chk(d[15:14], 2'b11);
    chk(interrupt_pin, 1'b1);
    rdreg(5'h03, 5'h00, 16'h3100);
    rdreg(5'h00, 5'h1F, 16'h0000);
    rdreg(5'h05, 5'h00, 16'hFFFF);
    en = 8'($random(seed)) & 8'hFE;
    if (en == 8'h00) en = 8'h02;
    wrreg(5'h00, 5'h1B, {en, 8'h5A});
    pulse(~en);
    chk(interrupt_pin, 1'b1);
    pulse(en);
    chk(interrupt_pin, 1'b0);
    rdreg(5'h03, 5'h1B, {en, 8'hFF});
    rdreg(5'h03, 5'h1B, {en, 8'h00});
    chk(interrupt_pin, 1'b1);
    wrreg(5'h03, 5'h1F, 16'h0200);
    chk(interrupt_pin, 1'b0);
    {pair1_sense, pair2_sense} <= 2'b10;
    repeat (8) @(posedge aclk);
    chk(mdix_active, 1'b1);
    {pair1_sense, pair2_sense} <= 2'b01;
    repeat (8) @(posedge aclk);
    chk(mdix_active, 1'b0);
    wrreg(5'h03, 5'h1F, 16'h6200);
    chk(mdix_active, 1'b1);
    wrreg(5'h03, 5'h00, 16'h4100);
    stream(0);
    wrreg(5'h03, 5'h1F, 16'h0208);
    stream(1);
    wrreg(5'h03, 5'h1F, 16'h0200);
    stream(0);
    wrreg(5'h03, 5'h00, 16'h2100);
    wrreg(5'h03, 5'h1F, 16'h0284);
    axi_rd(8'h00, d, r);
    chk(d[0], 1'b1);
    stream(2);
    wrreg(5'h00, 5'h16, 16'h0242);
    stream(3);
    rdreg(5'h00, 5'h00, 16'hFFFF);
    rdreg(5'h03, 5'h16, 16'h0242);
    rdreg(5'h03, 5'h1F, 16'h0284);
    wrap_up();
  end
endmodule : tb_top
